/* design/ipb_pkg.sv */
// package: register map, field layout and reset values of the priority bank
// assumes: a plain register port with a 4-bit word address and 16-bit data
package ipb_pkg;
   localparam int NUM_REGS = 5;
   localparam int NUM_SRC = 18;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int PRIO_W = 3;

   // word addresses of the five priority registers
   localparam logic [3:0] REG_ADDR [NUM_REGS] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7};

   // implemented bits per register, everything else reads zero
   localparam logic [15:0] REG_MASK [NUM_REGS] =
      '{16'h0777, 16'h7077, 16'h7777, 16'h7777, 16'h7777};

   // field codes: 000 off, 001 lowest, 111 highest, reset gives level four
   localparam logic [2:0] PRIO_OFF = 3'h0;
   localparam logic [2:0] PRIO_LOW = 3'h1;
   localparam logic [2:0] PRIO_TOP = 3'h7;
   localparam logic [2:0] PRIO_RESET = 3'h4;

   // source index order:
   // 0 dma ch1, 1 adc first, 2 uart first tx, 3 pin change, 4 i2c master,
   // 5 i2c slave, 6 capture 8, 7 capture 7, 8 adc second, 9 ext irq 1,
   // 10 timer 4, 11 compare 4, 12 compare 3, 13 dma ch2,
   // 14 uart second tx, 15 uart second rx, 16 ext irq 2, 17 timer 5
   localparam int FIELD_REG [NUM_SRC] =
      '{0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 4};
   localparam int FIELD_LSB [NUM_SRC] =
      '{8, 4, 0, 12, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0};

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } ipb_bus_req_type;

   typedef logic [NUM_REGS-1:0][DATA_W-1:0] ipb_view_type;
endpackage

/* design/ipb_field.sv */
// one 3-bit priority field with its enable decode
// assumes: write enable comes from same-clock address decode
`timescale 1ns/1ps
`default_nettype none
module ipb_field #(
   parameter logic [2:0] RESET_VALUE = ipb_pkg::PRIO_RESET
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // write side
   input wire logic wr_en,
   input wire logic [2:0] wdata,
   // field value
   output logic [2:0] level,
   output logic enabled
);
   logic [2:0] next_level;

   always_comb begin
      next_level = level;
      if (wr_en) begin
         next_level = wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         level <= RESET_VALUE;
      end else begin
         level <= next_level;
      end
   end

   // all-zero code switches the source off
   assign enabled = (level != ipb_pkg::PRIO_OFF);
endmodule
`default_nettype wire

/* design/ipb_readback.sv */
// read path: one-cycle registered read data for the priority bank
// assumes: read strobe is one cycle and never meets a write
`timescale 1ns/1ps
`default_nettype none
module ipb_readback (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // request
   input wire logic rd,
   input wire logic [ipb_pkg::ADDR_W-1:0] addr,
   input wire ipb_pkg::ipb_view_type view,
   // answer
   output logic [ipb_pkg::DATA_W-1:0] rd_data
);
   logic [ipb_pkg::DATA_W-1:0] next_rd_data;

   // data stands only in the cycle after the strobe, zero otherwise
   always_comb begin
      next_rd_data = '0;
      if (rd) begin
         for (int r = 0; r < ipb_pkg::NUM_REGS; r++) begin
            if (addr == ipb_pkg::REG_ADDR[r]) begin
               next_rd_data = view[r] & ipb_pkg::REG_MASK[r];
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= next_rd_data;
      end
   end
endmodule
`default_nettype wire

/* design/ipb_bank.sv */
// top of the interrupt priority bank: five registers, eighteen fields
// assumes: bus and flags come from logic on mclk; arbitration sits outside
//
// How it works
// - field code 111 gives its source level seven, the highest
// - code 001 gives level one; 010 to 110 give levels two to six
// - code 000 disables the source; no request leaves regardless of flag
// - unimplemented bits read as zero and ignore writes
// - reset loads every field with 100, level four
// - fields are read and written by software, reads return last write
// - register 0: dma ch1 10-8, adc first 6-4, uart first tx 2-0
// - register 1: pin change 14-12, i2c master 6-4, i2c slave 2-0
// - register 2: capture 8 14-12, capture 7 10-8, adc second 6-4, ext 1 2-0
// - register 3: timer 4 14-12, compare 4 10-8, compare 3 6-4, dma ch2 2-0
// - register 4: uart second tx 14-12, rx 10-8, ext 2 6-4, timer 5 2-0
`timescale 1ns/1ps
`default_nettype none
module ipb_bank (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // register port
   input wire ipb_pkg::ipb_bus_req_type bus_req,
   output logic [ipb_pkg::DATA_W-1:0] rd_data,
   // per-source flags in, gated requests out
   input wire logic [ipb_pkg::NUM_SRC-1:0] src_flag,
   output logic [ipb_pkg::NUM_SRC-1:0] src_request,
   output logic [ipb_pkg::NUM_SRC-1:0] src_enabled,
   // register 0 levels
   output logic [2:0] dma_ch1_done_level,
   output logic [2:0] adc_first_done_level,
   output logic [2:0] uart_first_tx_level,
   // register 1 levels
   output logic [2:0] pin_change_level,
   output logic [2:0] i2c_first_master_level,
   output logic [2:0] i2c_first_slave_level,
   // register 2 levels
   output logic [2:0] capture_eight_level,
   output logic [2:0] capture_seven_level,
   output logic [2:0] adc_second_done_level,
   output logic [2:0] ext_irq_one_level,
   // register 3 levels
   output logic [2:0] timer_four_level,
   output logic [2:0] compare_four_level,
   output logic [2:0] compare_three_level,
   output logic [2:0] dma_ch2_done_level,
   // register 4 levels
   output logic [2:0] uart_second_tx_level,
   output logic [2:0] uart_second_rx_level,
   output logic [2:0] ext_irq_two_level,
   output logic [2:0] timer_five_level
);
   logic [2:0] level_q [ipb_pkg::NUM_SRC];
   logic [ipb_pkg::NUM_SRC-1:0] field_wr;
   ipb_pkg::ipb_view_type view;
   logic [ipb_pkg::NUM_SRC-1:0] next_request;

   // one field per source; a write lands only in the slice it owns, so
   // bits outside every field are simply never stored
   for (genvar i = 0; i < ipb_pkg::NUM_SRC; i++) begin : g_field
      assign field_wr[i] = bus_req.wr &&
         (bus_req.addr == ipb_pkg::REG_ADDR[ipb_pkg::FIELD_REG[i]]);
      ipb_field #(
         .RESET_VALUE(ipb_pkg::PRIO_RESET)
      ) u_field (
         .mclk(mclk),
         .rst_n(rst_n),
         .wr_en(field_wr[i]),
         .wdata(bus_req.wdata[ipb_pkg::FIELD_LSB[i] +: 3]),
         .level(level_q[i]),
         .enabled(src_enabled[i])
      );
   end

   // register images built from the fields; holes stay zero
   always_comb begin
      view = '0;
      for (int i = 0; i < ipb_pkg::NUM_SRC; i++) begin
         view[ipb_pkg::FIELD_REG[i]][ipb_pkg::FIELD_LSB[i] +: 3] = level_q[i];
      end
   end

   ipb_readback u_readback (
      .mclk(mclk),
      .rst_n(rst_n),
      .rd(bus_req.rd),
      .addr(bus_req.addr),
      .view(view),
      .rd_data(rd_data)
   );

   // a disabled source is masked here, so its flag never reaches arbitration
   always_comb begin
      next_request = src_flag & src_enabled;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         src_request <= '0;
      end else begin
         src_request <= next_request;
      end
   end

   // levels pass straight from the field flops, no extra delay
   assign dma_ch1_done_level = level_q[0];
   assign adc_first_done_level = level_q[1];
   assign uart_first_tx_level = level_q[2];
   assign pin_change_level = level_q[3];
   assign i2c_first_master_level = level_q[4];
   assign i2c_first_slave_level = level_q[5];
   assign capture_eight_level = level_q[6];
   assign capture_seven_level = level_q[7];
   assign adc_second_done_level = level_q[8];
   assign ext_irq_one_level = level_q[9];
   assign timer_four_level = level_q[10];
   assign compare_four_level = level_q[11];
   assign compare_three_level = level_q[12];
   assign dma_ch2_done_level = level_q[13];
   assign uart_second_tx_level = level_q[14];
   assign uart_second_rx_level = level_q[15];
   assign ext_irq_two_level = level_q[16];
   assign timer_five_level = level_q[17];

   // checks
   logic [53:0] all_levels;
   logic addr_hit;

   always_comb begin
      all_levels = '0;
      addr_hit = 1'b0;
      for (int i = 0; i < ipb_pkg::NUM_SRC; i++) begin
         all_levels[i*3 +: 3] = level_q[i];
      end
      for (int r = 0; r < ipb_pkg::NUM_REGS; r++) begin
         if (bus_req.addr == ipb_pkg::REG_ADDR[r]) begin
            addr_hit = 1'b1;
         end
      end
   end

   sequence s_write_reg(logic [3:0] a);
      bus_req.wr && (bus_req.addr == a);
   endsequence

   sequence s_read_reg(logic [3:0] a);
      bus_req.rd && (bus_req.addr == a);
   endsequence

   property p_reset_level;
      @(posedge mclk) disable iff (!rst_n)
      $rose(rst_n) |-> (all_levels == {18{ipb_pkg::PRIO_RESET}});
   endproperty
   a_reset_level: assert property (p_reset_level)
      else $error("field not at level four after reset");

   property p_reg0_write;
      @(posedge mclk) disable iff (!rst_n)
      s_write_reg(4'h3) |=>
         (dma_ch1_done_level == $past(bus_req.wdata[10:8])) &&
         (adc_first_done_level == $past(bus_req.wdata[6:4])) &&
         (uart_first_tx_level == $past(bus_req.wdata[2:0]));
   endproperty
   a_reg0_write: assert property (p_reg0_write)
      else $error("register 0 write not taken");

   property p_reg1_write;
      @(posedge mclk) disable iff (!rst_n)
      s_write_reg(4'h4) |=>
         (pin_change_level == $past(bus_req.wdata[14:12])) &&
         (i2c_first_master_level == $past(bus_req.wdata[6:4])) &&
         (i2c_first_slave_level == $past(bus_req.wdata[2:0]));
   endproperty
   a_reg1_write: assert property (p_reg1_write)
      else $error("register 1 write not taken");

   property p_reg2_write;
      @(posedge mclk) disable iff (!rst_n)
      s_write_reg(4'h5) |=>
         (capture_eight_level == $past(bus_req.wdata[14:12])) &&
         (capture_seven_level == $past(bus_req.wdata[10:8])) &&
         (adc_second_done_level == $past(bus_req.wdata[6:4])) &&
         (ext_irq_one_level == $past(bus_req.wdata[2:0]));
   endproperty
   a_reg2_write: assert property (p_reg2_write)
      else $error("register 2 write not taken");

   property p_reg3_write;
      @(posedge mclk) disable iff (!rst_n)
      s_write_reg(4'h6) |=>
         (timer_four_level == $past(bus_req.wdata[14:12])) &&
         (compare_four_level == $past(bus_req.wdata[10:8])) &&
         (compare_three_level == $past(bus_req.wdata[6:4])) &&
         (dma_ch2_done_level == $past(bus_req.wdata[2:0]));
   endproperty
   a_reg3_write: assert property (p_reg3_write)
      else $error("register 3 write not taken");

   property p_reg4_write;
      @(posedge mclk) disable iff (!rst_n)
      s_write_reg(4'h7) |=>
         (uart_second_tx_level == $past(bus_req.wdata[14:12])) &&
         (uart_second_rx_level == $past(bus_req.wdata[10:8])) &&
         (ext_irq_two_level == $past(bus_req.wdata[6:4])) &&
         (timer_five_level == $past(bus_req.wdata[2:0]));
   endproperty
   a_reg4_write: assert property (p_reg4_write)
      else $error("register 4 write not taken");

   property p_hold_without_write;
      @(posedge mclk) disable iff (!rst_n)
      !bus_req.wr |=> $stable(all_levels);
   endproperty
   a_hold_without_write: assert property (p_hold_without_write)
      else $error("level changed with no write");

   property p_write_then_read;
      @(posedge mclk) disable iff (!rst_n)
      s_write_reg(4'h5) ##1 s_read_reg(4'h5) |=>
         (rd_data == ($past(bus_req.wdata, 2) & 16'h7777));
   endproperty
   a_write_then_read: assert property (p_write_then_read)
      else $error("read does not return last write");

   property p_read_reg0;
      @(posedge mclk) disable iff (!rst_n)
      s_read_reg(4'h3) |=>
         (rd_data == {5'h00, $past(dma_ch1_done_level), 1'b0,
                      $past(adc_first_done_level), 1'b0,
                      $past(uart_first_tx_level)});
   endproperty
   a_read_reg0: assert property (p_read_reg0)
      else $error("register 0 readback wrong");

   property p_read_reg1;
      @(posedge mclk) disable iff (!rst_n)
      s_read_reg(4'h4) |=>
         (rd_data == {1'b0, $past(pin_change_level), 5'h00,
                      $past(i2c_first_master_level), 1'b0,
                      $past(i2c_first_slave_level)});
   endproperty
   a_read_reg1: assert property (p_read_reg1)
      else $error("register 1 readback wrong");

   property p_read_reg2;
      @(posedge mclk) disable iff (!rst_n)
      s_read_reg(4'h5) |=>
         (rd_data == {1'b0, $past(capture_eight_level), 1'b0,
                      $past(capture_seven_level), 1'b0,
                      $past(adc_second_done_level), 1'b0, $past(ext_irq_one_level)});
   endproperty
   a_read_reg2: assert property (p_read_reg2)
      else $error("register 2 readback wrong");

   property p_read_reg3;
      @(posedge mclk) disable iff (!rst_n)
      s_read_reg(4'h6) |=>
         (rd_data == {1'b0, $past(timer_four_level), 1'b0,
                      $past(compare_four_level), 1'b0,
                      $past(compare_three_level), 1'b0, $past(dma_ch2_done_level)});
   endproperty
   a_read_reg3: assert property (p_read_reg3)
      else $error("register 3 readback wrong");

   property p_read_reg4;
      @(posedge mclk) disable iff (!rst_n)
      s_read_reg(4'h7) |=>
         (rd_data == {1'b0, $past(uart_second_tx_level), 1'b0,
                      $past(uart_second_rx_level), 1'b0,
                      $past(ext_irq_two_level), 1'b0, $past(timer_five_level)});
   endproperty
   a_read_reg4: assert property (p_read_reg4)
      else $error("register 4 readback wrong");

   // a read straight after a write must already see the new fields
   property p_write_then_read_reg0;
      @(posedge mclk) disable iff (!rst_n)
      s_write_reg(4'h3) ##1 s_read_reg(4'h3) |=>
         (rd_data == ($past(bus_req.wdata, 2) & 16'h0777));
   endproperty
   a_write_then_read_reg0: assert property (p_write_then_read_reg0)
      else $error("read after write misses new value");

   property p_unmapped_write;
      @(posedge mclk) disable iff (!rst_n)
      (bus_req.wr && !addr_hit) |=> $stable(all_levels);
   endproperty
   a_unmapped_write: assert property (p_unmapped_write)
      else $error("unmapped write changed a level");

   // a decode slip would let one register's write leak into its neighbour
   property p_reg1_write_spares_reg0;
      @(posedge mclk) disable iff (!rst_n)
      s_write_reg(4'h4) |=>
         $stable({dma_ch1_done_level, adc_first_done_level, uart_first_tx_level});
   endproperty
   a_reg1_write_spares_reg0: assert property (p_reg1_write_spares_reg0)
      else $error("register 1 write changed register 0");

   property p_reset_request;
      @(posedge mclk) disable iff (!rst_n)
      $rose(rst_n) |-> (src_request == '0);
   endproperty
   a_reset_request: assert property (p_reset_request)
      else $error("request raised straight after reset");

   property p_read_unmapped;
      @(posedge mclk) disable iff (!rst_n)
      (bus_req.rd && !addr_hit) |=> (rd_data == 16'h0000);
   endproperty
   a_read_unmapped: assert property (p_read_unmapped)
      else $error("unmapped read not zero");

   property p_read_idle;
      @(posedge mclk) disable iff (!rst_n)
      !bus_req.rd |=> (rd_data == 16'h0000);
   endproperty
   a_read_idle: assert property (p_read_idle)
      else $error("read data outside its cycle");

   property p_reserved_bits;
      @(posedge mclk) disable iff (!rst_n)
      (rd_data & 16'h8888) == 16'h0000;
   endproperty
   a_reserved_bits: assert property (p_reserved_bits)
      else $error("reserved bit reads one");

   for (genvar i = 0; i < ipb_pkg::NUM_SRC; i++) begin : g_chk
      property p_off_silent;
         @(posedge mclk) disable iff (!rst_n)
         (level_q[i] == 3'h0) |=> !src_request[i];
      endproperty
      a_off_silent: assert property (p_off_silent)
         else $error("disabled source raised a request");

      property p_on_passes;
         @(posedge mclk) disable iff (!rst_n)
         rst_n && (level_q[i] != 3'h0) && src_flag[i] |=> src_request[i];
      endproperty
      a_on_passes: assert property (p_on_passes)
         else $error("enabled source request lost");

      property p_top_passes;
         @(posedge mclk) disable iff (!rst_n)
         rst_n && (level_q[i] == 3'h7) && src_flag[i] |=>
            src_request[i] && $past(src_enabled[i]);
      endproperty
      a_top_passes: assert property (p_top_passes)
         else $error("level seven source not presented");
   end
endmodule
`default_nettype wire

/* tb/ipb_testbench.sv */
// self-checking bench for the priority bank: register port, levels, requests
// assumes: word addresses 3 to 7, read data one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct {
      logic [3:0] a;
      logic [15:0] d;
      logic [15:0] e;
   } ipb_tb_row_type;
   logic mclk;
   logic rst_n;
   ipb_pkg::ipb_bus_req_type bus_req;
   logic [15:0] rd_data;
   logic [17:0] src_flag;
   logic [17:0] src_request;
   logic [17:0] src_enabled;
   logic [2:0] lvl [18];
   logic [15:0] img [5];
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   // register and lowest bit of each source, in output index order
   int sreg [18] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 4};
   int slsb [18] = '{8, 4, 0, 12, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0};
   logic [15:0] rmask [5] = '{16'h0777, 16'h7077, 16'h7777, 16'h7777, 16'h7777};
   // all-ones writes probe the holes; two rows sweep every code 0 to 7
   ipb_tb_row_type rows [10] = '{
      '{4'h3, 16'hFFFF, 16'h0777}, '{4'h4, 16'hFFFF, 16'h7077},
      '{4'h5, 16'hFFFF, 16'h7777}, '{4'h6, 16'hFFFF, 16'h7777},
      '{4'h7, 16'hFFFF, 16'h7777}, '{4'h5, 16'h8123, 16'h0123},
      '{4'h6, 16'hC567, 16'h4567}, '{4'h3, 16'h0000, 16'h0000},
      '{4'h4, 16'hBAAA, 16'h3022}, '{4'h7, 16'h1234, 16'h1234}};

   ipb_bank DUT (
      .mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
      .src_flag(src_flag), .src_request(src_request), .src_enabled(src_enabled),
      .dma_ch1_done_level(lvl[0]), .adc_first_done_level(lvl[1]),
      .uart_first_tx_level(lvl[2]), .pin_change_level(lvl[3]),
      .i2c_first_master_level(lvl[4]), .i2c_first_slave_level(lvl[5]),
      .capture_eight_level(lvl[6]), .capture_seven_level(lvl[7]),
      .adc_second_done_level(lvl[8]), .ext_irq_one_level(lvl[9]),
      .timer_four_level(lvl[10]), .compare_four_level(lvl[11]),
      .compare_three_level(lvl[12]), .dma_ch2_done_level(lvl[13]),
      .uart_second_tx_level(lvl[14]), .uart_second_rx_level(lvl[15]),
      .ext_irq_two_level(lvl[16]), .timer_five_level(lvl[17])
   );

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results();
      if (mismatches == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic bus(input logic [3:0] a, input logic [15:0] d, input logic w,
                      input logic r);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      bus(a, 16'h0000, 1'b0, 1'b1);
      bus(4'h0, 16'h0000, 1'b0, 1'b0);
      @(negedge mclk);
      chk("rd_data", rd_data, e);
   endtask

   // levels from the image, then requests one cycle later with the bus idle
   task automatic chk_all();
      logic [17:0] en;
      for (int s = 0; s < 18; s++) begin
         en[s] = |((img[sreg[s]] >> slsb[s]) & 16'h0007);
         chk($sformatf("level %0d", s), lvl[s], (img[sreg[s]] >> slsb[s]) & 16'h0007);
      end
      chk("src_enabled", src_enabled, en);
      @(negedge mclk);
      chk("src_request", src_request, src_flag & en);
   endtask

   task automatic reset_img();
      for (int r = 0; r < 5; r++) begin
         img[r] = 16'h4444 & rmask[r];
      end
   endtask

   initial begin
      rst_n = 1'b0;
      bus_req = '0;
      src_flag = 18'h3FFFF;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk("rd_data", rd_data, 16'h0000);
      chk("src_request", src_request, 18'h00000);
      @(posedge mclk);
      rst_n <= 1'b1;
      reset_img();
      @(negedge mclk);
      chk_all();
      for (int r = 0; r < 5; r++) begin
         rd_chk(4'h3 + r[3:0], img[r]);
      end
      foreach (rows[i]) begin
         bus(rows[i].a, rows[i].d, 1'b1, 1'b0);
         src_flag <= i[0] ? 18'h15555 : 18'h2AAAA;
         bus(4'h0, 16'h0000, 1'b0, 1'b0);
         @(negedge mclk);
         img[rows[i].a - 4'h3] = rows[i].e;
         chk_all();
         rd_chk(rows[i].a, rows[i].e);
      end
      // unmapped places: writes vanish, reads give zero
      bus(4'h0, 16'hFFFF, 1'b1, 1'b0);
      bus(4'h8, 16'h0000, 1'b1, 1'b0);
      bus(4'hF, 16'h0000, 1'b1, 1'b0);
      bus(4'h0, 16'h0000, 1'b0, 1'b0);
      @(negedge mclk);
      chk_all();
      rd_chk(4'h0, 16'h0000);
      rd_chk(4'h2, 16'h0000);
      rd_chk(4'h8, 16'h0000);
      // write, read, read with no gaps; data stands one cycle only
      bus(4'h3, 16'hF765, 1'b1, 1'b0);
      bus(4'h3, 16'h0000, 1'b0, 1'b1);
      bus(4'h7, 16'h0000, 1'b0, 1'b1);
      @(negedge mclk);
      chk("rd_data", rd_data, 16'h0765);
      bus(4'h0, 16'h0000, 1'b0, 1'b0);
      @(negedge mclk);
      chk("rd_data", rd_data, img[4]);
      @(negedge mclk);
      chk("rd_data", rd_data, 16'h0000);
      bus(4'h5, 16'hF6E5, 1'b1, 1'b0);
      bus(4'h5, 16'h0000, 1'b0, 1'b1);
      bus(4'h0, 16'h0000, 1'b0, 1'b0);
      @(negedge mclk);
      chk("rd_data", rd_data, 16'h7665);
      // second reset in mid-run acts at once, without a clock edge
      @(posedge mclk);
      rst_n <= 1'b0;
      #1;
      for (int s = 0; s < 18; s++) begin
         chk($sformatf("level %0d", s), lvl[s], 32'h4);
      end
      chk("src_request", src_request, 18'h00000);
      @(posedge mclk);
      rst_n <= 1'b1;
      reset_img();
      @(negedge mclk);
      chk_all();
      rd_chk(4'h4, 16'h4044);
      results();
   end

   // hang guard: the sequence needs under a hundred cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         results();
      end
   end
endmodule
`default_nettype wire
